// [sdc_control_fields.v]
// decode and apply rf reference and if main divider word control fields
//
// What this block does
// - bit 23 selects slow/fast delay-line calibration
// - bit 22 enables the voltage doubler
// - bit 17 sets rf detector polarity
// - pump current is 100 uA times code+1
// - address 01 latches the if main word
// - if word fields: control, outputs, counts
// - plain mode: bits 17/18 drive pins A/B
// - bit 19 disables fractional spur compensation
// - bit 20 selects fast-settle, level bits ignored
// - fast-settle: pin A low when rf eight-weight
// - fast-settle: pin B low when if high gain
// - counter clear holds N and R counters
// - timed sleep waits for pump pulse end
// - immediate sleep acts at once on load
`timescale 1ns/10ps
`default_nettype none
`include "sdc_map.vh"

module sdc_control_fields (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        serialData,
    input  wire        serialClock,
    input  wire        latchStrobe,
    input  wire        pumpPulseDone,
    output reg         dllFastMode,
    output reg         doublerEnable,
    output reg         rfDetectorPolarity,
    output reg  [3:0]  rfPumpSetting,
    output reg  [10:0] rfPumpCurrentUa,
    output reg         rfPumpWeightEight,
    output reg         ifPumpHighGain,
    output reg  [2:0]  ifControlField,
    output reg         ifCounterClear,
    output reg         ifSleepTiming,
    output reg         ifLoopPoweredDown,
    output reg         fracCompDisable,
    output reg         fastSettleMode,
    output reg         auxPinA,
    output reg         auxPinAOe,
    output reg         auxPinB,
    output reg         auxPinBOe,
    output reg  [2:0]  ifSwallowCount,
    output reg  [11:0] ifProgramCount,
    output reg  [15:0] ifDivideRatio,
    output reg         ifRatioLegal
);

    // ==========================================================
    // serial capture
    wire                   wordValid;
    wire [`SDC_WORD_W-1:0] word;
    wire [1:0]             wordAddressBits;

    sdc_shift_in shifter (
        .clk         (clk),
        .rst_b       (rst_b),
        .serialData  (serialData),
        .serialClock (serialClock),
        .latchStrobe (latchStrobe),
        .wordValid   (wordValid),
        .word        (word)
    );

    assign wordAddressBits = word[`SDC_ADDR_HI:`SDC_ADDR_LO];

    // ==========================================================
    // word latches
    reg [`SDC_WORD_W-1:0] rfReferenceWord;
    reg [`SDC_WORD_W-1:0] ifMainDividerWord;
    reg                   ifReferenceGain;
    reg                   sleepRequest;
    wire                  loadIfMain;
    wire                  loadRfRef;
    wire                  loadIfRef;

    assign loadIfMain = wordValid & (wordAddressBits == `SDC_ADDR_IF_MAIN);
    assign loadRfRef  = wordValid & (wordAddressBits == `SDC_ADDR_RF_REF);
    assign loadIfRef  = wordValid & (wordAddressBits == `SDC_ADDR_IF_REF);

    // other addresses leave every latch as it was
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rfReferenceWord   <= `SDC_RST_WORD;
            ifMainDividerWord <= `SDC_RST_WORD;
            ifReferenceGain   <= `SDC_RST_BIT;
        end else begin
            if (loadIfMain) begin
                ifMainDividerWord <= word;
            end
            if (loadRfRef) begin
                rfReferenceWord <= word;
            end
            // only the gain bit of the if reference word is needed here
            if (loadIfRef) begin
                ifReferenceGain <= word[`SDC_IF_PUMP_GAIN];
            end
        end
    end

    // ==========================================================
    // rf reference fields
    wire [3:0] rfCode;
    wire       rfEight;

    assign rfCode  = rfReferenceWord[`SDC_RF_PUMP_HI:`SDC_RF_PUMP_LO];
    assign rfEight = rfReferenceWord[`SDC_RF_PUMP_HI];

    wire [10:0] next_rfPumpCurrentUa;
    assign next_rfPumpCurrentUa = `SDC_PUMP_STEP_UA * ({7'h00, rfCode} + 11'h001);

    // ==========================================================
    // if main fields
    wire        ctlClear;
    wire        ctlSleep;
    wire        ctlTiming;
    wire        ctlFast;
    wire [2:0]  swallow;
    wire [11:0] progCount;

    assign ctlClear  = ifMainDividerWord[`SDC_IF_CNT_CLEAR];
    assign ctlSleep  = ifMainDividerWord[`SDC_IF_SLEEP];
    assign ctlTiming = ifMainDividerWord[`SDC_IF_SLEEP_TIMING];
    assign ctlFast   = ifMainDividerWord[`SDC_IF_FAST_SETTLE];
    assign swallow   = ifMainDividerWord[`SDC_IF_SWALLOW_HI:`SDC_IF_SWALLOW_LO];
    assign progCount = ifMainDividerWord[`SDC_IF_PROG_HI:`SDC_IF_PROG_LO];

    // divide ratio of an 8/9 swallow divider: prescale times program plus swallow
    wire [15:0] next_ifDivideRatio;
    assign next_ifDivideRatio = (`SDC_IF_PRESCALE * {4'h0, progCount}) + {13'h0000, swallow};

    // flags settings that the host must not use; the device still obeys them
    wire next_ifRatioLegal;
    assign next_ifRatioLegal = (progCount >= `SDC_IF_PROG_MIN) &
                               (progCount >= {9'h000, swallow});

    // ==========================================================
    // auxiliary pins
    reg next_auxPinA;
    reg next_auxPinAOe;
    reg next_auxPinB;
    reg next_auxPinBOe;

    always @* begin
        if (ctlFast) begin
            // level bits are don't-care here; pins are low or released
            next_auxPinA   = 1'h0;
            next_auxPinAOe = rfEight;
            next_auxPinB   = 1'h0;
            next_auxPinBOe = ifReferenceGain;
        end else begin
            next_auxPinA   = ifMainDividerWord[`SDC_IF_AUX_A];
            next_auxPinAOe = 1'h1;
            next_auxPinB   = ifMainDividerWord[`SDC_IF_AUX_B];
            next_auxPinBOe = 1'h1;
        end
    end

    // ==========================================================
    // power down sequencing
    // timed mode: a request stays pending until the pump pulse ends;
    // power-up is always immediate so the loop never stays asleep by mistake
    reg next_ifLoopPoweredDown;
    reg next_sleepRequest;

    always @* begin
        next_sleepRequest      = sleepRequest;
        next_ifLoopPoweredDown = ifLoopPoweredDown;
        if (!ctlSleep) begin
            next_sleepRequest      = 1'h0;
            next_ifLoopPoweredDown = 1'h0;
        end else if (!ctlTiming) begin
            next_sleepRequest      = 1'h0;
            next_ifLoopPoweredDown = 1'h1;
        end else if (!ifLoopPoweredDown) begin
            next_sleepRequest = 1'h1;
            if (pumpPulseDone) begin
                next_sleepRequest      = 1'h0;
                next_ifLoopPoweredDown = 1'h1;
            end
        end
    end

    // ==========================================================
    // output registers
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dllFastMode        <= 1'h0;
            doublerEnable      <= 1'h0;
            rfDetectorPolarity <= 1'h0;
            rfPumpSetting      <= 4'h0;
            rfPumpCurrentUa    <= `SDC_PUMP_STEP_UA;
            rfPumpWeightEight  <= 1'h0;
            ifPumpHighGain     <= 1'h0;
            ifControlField     <= 3'h0;
            ifCounterClear     <= 1'h0;
            ifSleepTiming      <= 1'h0;
            ifLoopPoweredDown  <= 1'h0;
            sleepRequest       <= 1'h0;
            fracCompDisable    <= 1'h0;
            fastSettleMode     <= 1'h0;
            auxPinA            <= 1'h0;
            auxPinAOe          <= 1'h1;
            auxPinB            <= 1'h0;
            auxPinBOe          <= 1'h1;
            ifSwallowCount     <= 3'h0;
            ifProgramCount     <= 12'h000;
            ifDivideRatio      <= 16'h0000;
            ifRatioLegal       <= 1'h0;
        end else begin
            dllFastMode        <= rfReferenceWord[`SDC_RF_DLL_MODE];
            doublerEnable      <= rfReferenceWord[`SDC_RF_DOUBLER];
            rfDetectorPolarity <= rfReferenceWord[`SDC_RF_POLARITY];
            rfPumpSetting      <= rfCode;
            rfPumpCurrentUa    <= next_rfPumpCurrentUa;
            rfPumpWeightEight  <= rfEight;
            ifPumpHighGain     <= ifReferenceGain;
            ifControlField     <= ifMainDividerWord[`SDC_IF_CNT_CLEAR:`SDC_IF_SLEEP_TIMING];
            ifCounterClear     <= ctlClear;
            ifSleepTiming      <= ctlTiming;
            ifLoopPoweredDown  <= next_ifLoopPoweredDown;
            sleepRequest       <= next_sleepRequest;
            fracCompDisable    <= ifMainDividerWord[`SDC_IF_FRAC_TEST];
            fastSettleMode     <= ctlFast;
            auxPinA            <= next_auxPinA;
            auxPinAOe          <= next_auxPinAOe;
            auxPinB            <= next_auxPinB;
            auxPinBOe          <= next_auxPinBOe;
            ifSwallowCount     <= swallow;
            ifProgramCount     <= progCount;
            ifDivideRatio      <= next_ifDivideRatio;
            ifRatioLegal       <= next_ifRatioLegal;
        end
    end

endmodule // sdc_control_fields
`default_nettype wire

// [sdc_fields_chk.sv]
// concurrent checks on the control field outputs
`timescale 1ns/10ps
`default_nettype none
module sdc_fields_chk (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        latchStrobe,
    input wire logic        pumpPulseDone,
    input wire logic        dllFastMode,
    input wire logic        doublerEnable,
    input wire logic        rfDetectorPolarity,
    input wire logic [3:0]  rfPumpSetting,
    input wire logic [10:0] rfPumpCurrentUa,
    input wire logic        rfPumpWeightEight,
    input wire logic        ifPumpHighGain,
    input wire logic [2:0]  ifControlField,
    input wire logic        ifCounterClear,
    input wire logic        ifLoopPoweredDown,
    input wire logic        fracCompDisable,
    input wire logic        fastSettleMode,
    input wire logic        auxPinA,
    input wire logic        auxPinAOe,
    input wire logic        auxPinB,
    input wire logic        auxPinBOe,
    input wire logic [2:0]  ifSwallowCount,
    input wire logic [11:0] ifProgramCount,
    input wire logic [15:0] ifDivideRatio
);
    // ====================
    // strobe edge delayed to the sample where new fields first show
    logic sQ, rise1, rise2, rise3;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {sQ, rise1, rise2, rise3} <= 4'h0;
        end else begin
            sQ <= latchStrobe;
            rise1 <= latchStrobe & ~sQ;
            rise2 <= rise1;
            rise3 <= rise2;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ====================
    // assertions
    chk_pump_current: assert property (
        rfPumpCurrentUa == 11'h064 * ({7'h0, rfPumpSetting} + 11'h001)
        && rfPumpWeightEight == rfPumpSetting[3]) else $error("pump current wrong");
    chk_plain_pins: assert property (!fastSettleMode |-> auxPinAOe && auxPinBOe)
        else $error("plain mode pins not driven");
    chk_fast_pin_a: assert property (
        fastSettleMode |-> !auxPinA && auxPinAOe == rfPumpWeightEight) else $error("pin a");
    chk_fast_pin_b: assert property (
        fastSettleMode |-> !auxPinB && auxPinBOe == ifPumpHighGain) else $error("pin b");
    chk_ratio_sum: assert property (
        ifDivideRatio == {1'b0, ifProgramCount, 3'h0} + {13'h0, ifSwallowCount})
        else $error("divide ratio wrong");
    chk_fields_hold: assert property (!rise3 |-> $stable({dllFastMode, doublerEnable,
        rfDetectorPolarity, rfPumpSetting, ifPumpHighGain, ifControlField, fracCompDisable,
        fastSettleMode, ifSwallowCount, ifProgramCount})) else $error("field moved");
    chk_sleep_quick: assert property (
        rise3 && ifControlField[1] && !ifControlField[0] |-> ifLoopPoweredDown)
        else $error("immediate sleep late");
    chk_sleep_wait: assert property (
        !rise1 && !rise2 && ifControlField[1:0] == 2'h3 && !ifLoopPoweredDown && !pumpPulseDone
        |=> !ifLoopPoweredDown) else $error("timed sleep early");
    chk_sleep_gated: assert property (
        !rise1 && !rise2 && ifControlField[1:0] == 2'h3 && pumpPulseDone |=> ifLoopPoweredDown)
        else $error("timed sleep missed");
    chk_sleep_clear: assert property (!ifControlField[1] |-> !ifLoopPoweredDown)
        else $error("loop down while awake");
    chk_clear_bit: assert property (ifCounterClear == ifControlField[2])
        else $error("counter clear wrong");
endmodule // sdc_fields_chk
`default_nettype wire

// [sdc_host_model.sv]
// host controller model that shifts 24-bit words and raises the latch strobe
`timescale 1ns/10ps
`default_nettype none
module sdc_host_model (
    input  wire logic clk,
    output logic      serialData,
    output logic      serialClock,
    output logic      latchStrobe
);
    // ====================
    // word transfer
    initial begin
        serialData = 1'b0;
        serialClock = 1'b0;
        latchStrobe = 1'b0;
    end
    // msb first, each clock phase one cycle wide, strobe after the last bit
    task automatic send(input logic [23:0] w);
        integer b;
        begin
            for (b = 23; b >= 0; b--) begin
                @(posedge clk);
                serialData <= w[b];
                serialClock <= 1'b0;
                @(posedge clk);
                serialClock <= 1'b1;
            end
            @(posedge clk);
            serialClock <= 1'b0;
            // released data line shows the inverse so a stale bit is never trusted
            serialData <= ~w[0];
            @(posedge clk);
            latchStrobe <= 1'b1;
            @(posedge clk);
            latchStrobe <= 1'b0;
        end
    endtask
endmodule // sdc_host_model
`default_nettype wire

// [sdc_map.vh]
// field positions, codes and reset values of the synthesizer control words
`ifndef SDC_MAP_VH
`define SDC_MAP_VH

// serial word layout
`define SDC_WORD_W          24
`define SDC_ADDR_HI         1
`define SDC_ADDR_LO         0
`define SDC_ADDR_IF_REF     2'h0
`define SDC_ADDR_IF_MAIN    2'h1
`define SDC_ADDR_RF_REF     2'h2
`define SDC_ADDR_RF_MAIN    2'h3

// reference words
`define SDC_RF_DLL_MODE     23
`define SDC_RF_DOUBLER      22
`define SDC_RF_PUMP_HI      21
`define SDC_RF_PUMP_LO      18
`define SDC_RF_POLARITY     17
`define SDC_IF_PUMP_GAIN    18

// if main divider word
`define SDC_IF_CNT_CLEAR    23
`define SDC_IF_SLEEP        22
`define SDC_IF_SLEEP_TIMING 21
`define SDC_IF_FAST_SETTLE  20
`define SDC_IF_FRAC_TEST    19
`define SDC_IF_AUX_B        18
`define SDC_IF_AUX_A        17
`define SDC_IF_PROG_HI      16
`define SDC_IF_PROG_LO      5
`define SDC_IF_SWALLOW_HI   4
`define SDC_IF_SWALLOW_LO   2

// pump current step and if prescaler modulus
`define SDC_PUMP_STEP_UA    11'h064
`define SDC_IF_PRESCALE     16'h0008
`define SDC_IF_PROG_MIN     12'h003

// reset values
`define SDC_RST_WORD        24'h000000
`define SDC_RST_BIT         1'h0

`endif

// [sdc_shift_in.v]
// serial shift register and latch strobe capture for 24-bit control words
`timescale 1ns/10ps
`default_nettype none
`include "sdc_map.vh"

module sdc_shift_in (
    input  wire                   clk,
    input  wire                   rst_b,
    input  wire                   serialData,
    input  wire                   serialClock,
    input  wire                   latchStrobe,
    output reg                    wordValid,
    output reg  [`SDC_WORD_W-1:0] word
);

    // ==========================================================
    // edge detection
    reg                   serialClockDly;
    reg                   latchStrobeDly;
    reg [`SDC_WORD_W-1:0] shiftReg;
    wire                  shiftEdge;
    wire                  latchEdge;

    assign shiftEdge = serialClock & ~serialClockDly;
    assign latchEdge = latchStrobe & ~latchStrobeDly;

    // ==========================================================
    // shifter, msb first
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            serialClockDly <= 1'h0;
            latchStrobeDly <= 1'h0;
            shiftReg       <= `SDC_RST_WORD;
            wordValid      <= 1'h0;
            word           <= `SDC_RST_WORD;
        end else begin
            serialClockDly <= serialClock;
            latchStrobeDly <= latchStrobe;
            wordValid      <= latchEdge;
            if (shiftEdge) begin
                shiftReg <= {shiftReg[`SDC_WORD_W-2:0], serialData};
            end
            // a shift edge in the same cycle as the latch edge is not included
            if (latchEdge) begin
                word <= shiftReg;
            end
        end
    end

endmodule // sdc_shift_in
`default_nettype wire

// [tb.sv]
// self-checking bench for the synthesizer control field decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin nMismatch++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic clk, rst_b, serialData, serialClock, latchStrobe, pumpPulseDone;
    logic dllFastMode, doublerEnable, rfDetectorPolarity, rfPumpWeightEight, ifPumpHighGain;
    logic ifCounterClear, ifSleepTiming, ifLoopPoweredDown, fracCompDisable, fastSettleMode;
    logic auxPinA, auxPinAOe, auxPinB, auxPinBOe, ifRatioLegal;
    logic [3:0]  rfPumpSetting;
    logic [10:0] rfPumpCurrentUa;
    logic [2:0]  ifControlField, ifSwallowCount;
    logic [11:0] ifProgramCount;
    logic [15:0] ifDivideRatio;
    integer nMismatch = 0, numChecks = 0, i;
    sdc_control_fields uut (.*);
    sdc_host_model host (.*);
    // ====================
    // clock, tasks
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic test_done;
        begin
            $display("checks %0d mismatches %0d", numChecks, nMismatch);
            if (nMismatch == 0 && numChecks > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // outputs follow two edges after the strobe edge is seen
    task automatic load(input logic [23:0] w);
        begin
            host.send(w);
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    task automatic checkIf(input logic [2:0] c, input logic [3:0] m, input logic [11:0] p,
                           input logic [2:0] s);
        begin
            load({c, m, p, s, 2'h1});
            `CHK("control", c, ifControlField)
            `CHK("clear", c[2], ifCounterClear)
            `CHK("timing", c[0], ifSleepTiming)
            `CHK("frac", m[2], fracCompDisable)
            `CHK("fast", m[3], fastSettleMode)
            `CHK("counts", {p, s}, {ifProgramCount, ifSwallowCount})
            `CHK("ratio", {1'b0, p, 3'h0} + {13'h0, s}, ifDivideRatio)
            `CHK("legal", p >= 12'h003 && p >= {9'h0, s}, ifRatioLegal)
            if (!m[3]) `CHK("pins", {m[1:0], 2'h3}, {auxPinB, auxPinA, auxPinBOe, auxPinAOe})
            if (!c[0]) `CHK("sleep", c[1], ifLoopPoweredDown)
        end
    endtask
    // ====================
    // scenarios
    initial begin
        rst_b = 1'b0;
        pumpPulseDone = 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        `CHK("reset current", 11'h064, rfPumpCurrentUa)
        `CHK("reset pins", 2'h3, {auxPinAOe, auxPinBOe})
        for (i = 0; i < 16; i++) begin
            load({i[0], i[1], i[3:0], ~i[2], 15'h0, 2'h2});
            `CHK("dll", i[0], dllFastMode)
            `CHK("doubler", i[1], doublerEnable)
            `CHK("polarity", ~i[2], rfDetectorPolarity)
            `CHK("setting", i[3:0], rfPumpSetting)
            `CHK("current", 11'(100 * (i + 1)), rfPumpCurrentUa)
            `CHK("weight", i[3], rfPumpWeightEight)
        end
        checkIf(3'h0, 4'h1, 12'h007, 3'h0);
        checkIf(3'h4, 4'h6, 12'hfff, 3'h7);
        checkIf(3'h0, 4'h3, 12'h003, 3'h5);
        checkIf(3'h2, 4'h0, 12'h002, 3'h0);
        load(24'hffffff);
        load(24'h040000);
        `CHK("kept if", 12'h002, ifProgramCount)
        `CHK("kept rf", 4'hf, rfPumpSetting)
        `CHK("gain", 1'b1, ifPumpHighGain)
        checkIf(3'h0, 4'h9, 12'h010, 3'h1);
        `CHK("fast pins", 4'h3, {auxPinB, auxPinA, auxPinBOe, auxPinAOe})
        load(24'h1c0002);
        `CHK("pin a off", 1'b0, auxPinAOe)
        load(24'h000000);
        `CHK("pin b off", 1'b0, auxPinBOe)
        checkIf(3'h3, 4'h0, 12'h020, 3'h0);
        repeat (3) @(posedge clk);
        #1;
        `CHK("sleep waits", 1'b0, ifLoopPoweredDown)
        @(posedge clk);
        pumpPulseDone <= 1'b1;
        @(posedge clk);
        pumpPulseDone <= 1'b0;
        #1;
        `CHK("sleep after pulse", 1'b1, ifLoopPoweredDown)
        checkIf(3'h0, 4'h0, 12'h038, 3'h0);
        test_done;
    end
    // a hung transfer must still reach the verdict
    initial begin
        repeat (20000) @(posedge clk);
        nMismatch++;
        test_done;
    end
endmodule // tb
bind sdc_control_fields sdc_fields_chk chk (.*);
`default_nettype wire
